// ===== inc/bridge_map_pkg.sv
// address map, register layout and access timing for the core bridge
package bridge_map_pkg;
    // physical and program address widths
    localparam int PHYS_W = 28;
    localparam int PROG_W = 26;
    // data-side physical map
    localparam logic [27:0] ROM_HI = 28'h00FFFFF;
    localparam logic [27:0] RAM_END = 28'hFFFF000;
    localparam logic [27:0] RAM_KB_BYTES = 28'h0000400;
    localparam logic [1:0] RAM_TAG = 2'h3;
    localparam logic [1:0] ALIAS_TAG = 2'h0;
    localparam logic [27:0] PERI_LO = 28'hFFFF000;
    localparam logic [27:0] WORD_ALIGN = 28'hFFFFFFC;
    localparam logic [27:0] HALF_STEP = 28'h0000002;
    // program-side map
    localparam logic [25:0] PROG_ROM_END = 26'h0100000;
    localparam logic [25:0] PROG_PERI_LO = 26'h3FFF000;
    localparam logic [25:0] PROG_STEP = 26'h0000004;
    localparam logic [25:0] PROG_RESET = 26'h0000000;
    localparam logic [25:0] EXC_TABLE_BASE = 26'h0000000;
    localparam int EXC_SHIFT = 4;
    // register offsets
    localparam logic [31:0] WIN_CTRL_ADDR = 32'hFFFFF064;
    localparam logic [31:0] WAIT_CTRL_ADDR = 32'hFFFFF06E;
    // window control layout
    localparam int WIN_EN_BIT = 15;
    localparam int WIN_ZERO_BIT = 14;
    localparam int WIN_BASE_W = 14;
    localparam int WIN_SHIFT = 14;
    localparam logic WIN_EN_RESET = 1'b0;
    localparam logic [13:0] WIN_BASE_RESET = 14'h0000;
    localparam logic [15:0] WIN_RD_ON = 16'h8FFB;
    localparam logic [15:0] WIN_RD_OFF = 16'h0000;
    // wait control layout
    localparam logic [7:0] WAIT_RESET = 8'h77;
    localparam logic [7:0] WAIT_MASK = 8'h77;
    localparam int SETUP_LSB = 4;
    localparam int STROBE_LSB = 0;
    localparam int WAIT_W = 3;
    // access clocks
    localparam logic [4:0] FETCH_SEQ_CLK = 5'h01;
    localparam logic [4:0] FETCH_BR_CLK = 5'h02;
    localparam logic [4:0] ROM_OP_CLK = 5'h03;
    localparam logic [4:0] RAM_OP_CLK = 5'h01;
    localparam logic [4:0] PERI_OP_CLK = 5'h03;
    localparam logic [4:0] NONE_OP_CLK = 5'h03;
    typedef enum logic [2:0] {
        RGN_NONE, RGN_ROM, RGN_RAM, RGN_PERI, RGN_WIN
    } region_t;
    typedef enum logic [1:0] {SZ_BYTE, SZ_HALF, SZ_WORD} size_t;
endpackage

// ===== hw/core_bus_bridge.sv
// address decode, access timing and size split between core and memories
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/100ps

// Summary of operation
// - program counter upper six bits stay zero
// - branch carry out of bit 25 dropped
// - operand address sum truncated to 32 bits
// - internal ROM at first 1 MB
// - exceptions jump to handler table in ROM
// - internal RAM below peripheral area, up to 12 KB
// - RAM also seen at 3FF alias
// - peripheral 4 KB area, fetches refused
// - word peripheral access: two halves, low first
// - byte register by halfword: low byte written
// - 16 KB window base from base field
// - bit 15 enables window, fixed read values
// - window control is 16-bit, bit 14 zero
// - fixed ROM and RAM access clocks
// - peripheral access: 3 plus programmed waits
// - wait register resets 77H, two 3-bit fields
// - wait register takes bit and byte access
// - data decode ignores address bits 31..28
module core_bus_bridge #(
    parameter int RAM_KB = 12,
    parameter int EXC_W = 8
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // instruction fetch
    input wire logic fetch_req,
    input wire logic fetch_branch,
    input wire logic [31:0] fetch_disp,
    input wire logic exc_ack,
    input wire logic [EXC_W-1:0] exc_code,
    output logic fetch_done,
    output logic fetch_fault,
    output logic [31:0] program_counter,
    // operand access
    input wire logic op_req,
    input wire logic [31:0] op_base,
    input wire logic [31:0] op_disp,
    input wire bridge_map_pkg::size_t op_size,
    input wire logic op_we,
    input wire logic [31:0] op_wdata,
    output logic op_busy,
    output logic op_done,
    output logic [31:0] op_rdata,
    // memory and peripheral side
    output logic dn_req,
    output bridge_map_pkg::region_t dn_region,
    output logic [27:0] dn_addr,
    output logic dn_we,
    output bridge_map_pkg::size_t dn_size,
    output logic [31:0] dn_wdata,
    input wire logic [31:0] dn_rdata,
    // register port
    input wire logic [31:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // configuration seen by the memories
    output logic window_access_enable,
    output logic [13:0] window_base_field,
    output logic [2:0] setup_wait,
    output logic [2:0] strobe_wait
);
    import bridge_map_pkg::*;

    localparam logic [27:0] RAM_LO =
        RAM_END - 28'(RAM_KB) * RAM_KB_BYTES;

    if (!(RAM_KB == 12 || RAM_KB == 10 || RAM_KB == 8)) begin : g_ram_chk
        $error("RAM_KB must be 8, 10 or 12");
    end
    if (EXC_W < 1 || EXC_W > PROG_W - EXC_SHIFT) begin : g_exc_chk
        $error("EXC_W out of range");
    end

    typedef enum {OP_IDLE, OP_FIRST, OP_SECOND} op_state_t;

    // ----------------------------------------------------------------
    // decode functions
    // ----------------------------------------------------------------
    function automatic logic ram_hit(input logic [27:0] a);
        logic [27:0] m;
        m = {RAM_TAG, a[25:0]};
        ram_hit = (a[27:26] == RAM_TAG || a[27:26] == ALIAS_TAG) &&
            m >= RAM_LO && m < RAM_END;
    endfunction

    function automatic region_t decode(input logic [27:0] a,
        input logic en, input logic [13:0] base);
        decode = RGN_NONE;
        if (a <= ROM_HI) begin
            decode = RGN_ROM;
        end else if (a >= PERI_LO) begin
            decode = RGN_PERI;
        end else if (ram_hit(a)) begin
            decode = RGN_RAM;
        end else if (en && a[27:WIN_SHIFT] == base) begin
            decode = RGN_WIN;
        end
    endfunction

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic win_en_q;
    logic [13:0] win_base_q;
    logic [7:0] wait_q;
    logic [15:0] reg_rdata_q;
    logic wr_win;
    logic wr_wait;

    assign wr_win = reg_wr && reg_addr == WIN_CTRL_ADDR;
    assign wr_wait = reg_wr && reg_addr == WAIT_CTRL_ADDR;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            win_en_q <= WIN_EN_RESET;
            win_base_q <= WIN_BASE_RESET;
        end else if (wr_win) begin
            win_en_q <= reg_wdata[WIN_EN_BIT];
            win_base_q <= reg_wdata[WIN_BASE_W-1:0];
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wait_q <= WAIT_RESET;
        end else if (wr_wait) begin
            // low byte only, whatever the access width
            wait_q <= reg_wdata[7:0] & WAIT_MASK;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata_q <= 16'h0000;
        end else if (reg_rd && reg_addr == WIN_CTRL_ADDR) begin
            reg_rdata_q <= win_en_q ? WIN_RD_ON : WIN_RD_OFF;
        end else if (reg_rd && reg_addr == WAIT_CTRL_ADDR) begin
            reg_rdata_q <= {8'h00, wait_q};
        end else begin
            reg_rdata_q <= 16'h0000;
        end
    end

    assign reg_rdata = reg_rdata_q;
    assign window_access_enable = win_en_q;
    assign window_base_field = win_base_q;
    assign setup_wait = wait_q[SETUP_LSB+WAIT_W-1:SETUP_LSB];
    assign strobe_wait = wait_q[STROBE_LSB+WAIT_W-1:STROBE_LSB];

    // ----------------------------------------------------------------
    // instruction fetch
    // ----------------------------------------------------------------
    logic [25:0] prog_q;
    logic [31:0] prog_out_q;
    logic fbusy_q;
    logic fdone_q;
    logic ffault_q;
    logic fpend_q;
    logic [4:0] fcnt_q;
    logic f_go;
    logic f_bad;
    logic [25:0] f_tgt;
    logic [4:0] f_lat;

    assign f_go = (fetch_req || exc_ack) && !fbusy_q;

    always_comb begin
        if (exc_ack) begin
            f_tgt = EXC_TABLE_BASE +
                26'({exc_code, {EXC_SHIFT{1'b0}}});
        end else if (fetch_branch) begin
            f_tgt = prog_q + fetch_disp[25:0];
        end else begin
            f_tgt = prog_q;
        end
        f_bad = f_tgt >= PROG_PERI_LO ||
            !(f_tgt < PROG_ROM_END || ram_hit({ALIAS_TAG, f_tgt}));
        if (f_bad || !(exc_ack || fetch_branch)) begin
            f_lat = FETCH_SEQ_CLK;
        end else begin
            f_lat = FETCH_BR_CLK;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            prog_q <= PROG_RESET;
            prog_out_q <= 32'h00000000;
            fbusy_q <= 1'b0;
            fdone_q <= 1'b0;
            ffault_q <= 1'b0;
            fpend_q <= 1'b0;
            fcnt_q <= 5'h00;
        end else begin
            fdone_q <= 1'b0;
            ffault_q <= 1'b0;
            if (f_go) begin
                prog_out_q <= {6'h00, f_tgt};
                fpend_q <= f_bad;
                fcnt_q <= f_lat - 5'h01;
                fbusy_q <= 1'b1;
                if (!f_bad) begin
                    prog_q <= f_tgt + PROG_STEP;
                end
            end else if (fbusy_q) begin
                if (fcnt_q == 5'h00) begin
                    fbusy_q <= 1'b0;
                    fdone_q <= 1'b1;
                    ffault_q <= fpend_q;
                end else begin
                    fcnt_q <= fcnt_q - 5'h01;
                end
            end
        end
    end

    assign fetch_done = fdone_q;
    assign fetch_fault = ffault_q;
    assign program_counter = prog_out_q;

    // ----------------------------------------------------------------
    // operand access
    // ----------------------------------------------------------------
    op_state_t state_q;
    logic [31:0] o_addr;
    logic [27:0] o_phys;
    region_t o_rgn;
    logic [4:0] o_lat;
    logic o_split;
    logic [4:0] olat_q;
    logic [4:0] ocnt_q;
    logic osplit_q;
    logic obusy_q;
    logic odone_q;
    logic [31:0] ordata_q;
    logic dreq_q;
    region_t drgn_q;
    logic [27:0] daddr_q;
    logic dwe_q;
    size_t dsize_q;
    logic [31:0] dwdata_q;

    always_comb begin
        o_addr = op_base + op_disp;
        o_phys = o_addr[27:0];
        o_rgn = decode(o_phys, win_en_q, win_base_q);
        case (o_rgn)
            RGN_ROM: o_lat = ROM_OP_CLK;
            RGN_RAM: o_lat = RAM_OP_CLK;
            RGN_PERI, RGN_WIN: begin
                o_lat = PERI_OP_CLK + 5'(setup_wait) +
                    5'(strobe_wait);
            end
            default: o_lat = NONE_OP_CLK;
        endcase
        o_split = (o_rgn == RGN_PERI || o_rgn == RGN_WIN) &&
            op_size == SZ_WORD;
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= OP_IDLE;
            olat_q <= 5'h00;
            ocnt_q <= 5'h00;
            osplit_q <= 1'b0;
            obusy_q <= 1'b0;
            odone_q <= 1'b0;
            ordata_q <= 32'h00000000;
            dreq_q <= 1'b0;
            drgn_q <= RGN_NONE;
            daddr_q <= 28'h0000000;
            dwe_q <= 1'b0;
            dsize_q <= SZ_BYTE;
            dwdata_q <= 32'h00000000;
        end else begin
            dreq_q <= 1'b0;
            odone_q <= 1'b0;
            case (state_q)
                OP_IDLE: begin
                    if (op_req) begin
                        drgn_q <= o_rgn;
                        dreq_q <= o_rgn != RGN_NONE;
                        // word split ignores low address bits
                        daddr_q <= o_split ? o_phys & WORD_ALIGN : o_phys;
                        dsize_q <= o_split ? SZ_HALF : op_size;
                        dwe_q <= op_we;
                        dwdata_q <= op_wdata;
                        olat_q <= o_lat;
                        ocnt_q <= o_lat - 5'h01;
                        osplit_q <= o_split;
                        obusy_q <= 1'b1;
                        state_q <= OP_FIRST;
                    end
                end
                OP_FIRST: begin
                    if (ocnt_q != 5'h00) begin
                        ocnt_q <= ocnt_q - 5'h01;
                    end else if (osplit_q) begin
                        // low half done, start upper half
                        ordata_q <= {16'h0000, dn_rdata[15:0]};
                        dreq_q <= 1'b1;
                        daddr_q <= daddr_q + HALF_STEP;
                        dwdata_q <= {16'h0000, dwdata_q[31:16]};
                        ocnt_q <= olat_q - 5'h01;
                        state_q <= OP_SECOND;
                    end else begin
                        ordata_q <= drgn_q == RGN_NONE ?
                            32'h00000000 : dn_rdata;
                        odone_q <= 1'b1;
                        obusy_q <= 1'b0;
                        state_q <= OP_IDLE;
                    end
                end
                OP_SECOND: begin
                    if (ocnt_q != 5'h00) begin
                        ocnt_q <= ocnt_q - 5'h01;
                    end else begin
                        ordata_q <= {dn_rdata[15:0], ordata_q[15:0]};
                        odone_q <= 1'b1;
                        obusy_q <= 1'b0;
                        state_q <= OP_IDLE;
                    end
                end
                default: begin
                    state_q <= OP_IDLE;
                end
            endcase
        end
    end

    assign op_busy = obusy_q;
    assign op_done = odone_q;
    assign op_rdata = ordata_q;
    assign dn_req = dreq_q;
    assign dn_region = drgn_q;
    assign dn_addr = daddr_q;
    assign dn_we = dwe_q;
    assign dn_size = dsize_q;
    assign dn_wdata = dwdata_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    logic [5:0] h_elapsed_q;
    logic [5:0] h_expect_q;
    logic o_go;

    assign o_go = op_req && state_q == OP_IDLE;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            h_elapsed_q <= 6'h00;
            h_expect_q <= 6'h00;
        end else if (o_go) begin
            h_elapsed_q <= 6'h01;
            h_expect_q <= o_split ? {o_lat, 1'b0} : {1'b0, o_lat};
        end else if (obusy_q) begin
            h_elapsed_q <= h_elapsed_q + 6'h01;
        end
    end

    sequence s_first_half;
        dn_req && daddr_q[1:0] == 2'h0;
    endsequence
    sequence s_second_half;
        dn_req && daddr_q[1:0] == 2'h2;
    endsequence

    AST_PROG_UPPER_ZERO: assert property (
        program_counter[31:26] == 6'h00)
        else $error("program counter upper bits not zero");
    AST_BRANCH_WRAP: assert property (
        f_go && !exc_ack && fetch_branch |=>
        program_counter[25:0] == $past(prog_q) + $past(fetch_disp[25:0]))
        else $error("branch target not wrapped in 26 bits");
    AST_FETCH_REFUSED: assert property (
        f_go && f_tgt >= PROG_PERI_LO |-> ##2 fetch_done && fetch_fault)
        else $error("fetch from peripheral area not refused");
    AST_EXC_VECTOR: assert property (
        f_go && exc_ack |=> program_counter[25:0] < PROG_ROM_END
        ##2 fetch_done)
        else $error("exception target outside ROM or late");
    AST_ROM_CLOCKS: assert property (
        o_go && o_rgn == RGN_ROM |=> !op_done [*3] ##1 op_done)
        else $error("ROM operand access not 3 clocks");
    AST_RAM_CLOCKS: assert property (
        o_go && o_rgn == RGN_RAM |=> !op_done ##1 op_done)
        else $error("RAM operand access not 1 clock");
    AST_PERI_CLOCKS: assert property (
        op_done |-> h_elapsed_q == h_expect_q + 6'h01)
        else $error("operand access length wrong");
    AST_WORD_SPLIT: assert property (
        o_go && o_split |=> s_first_half ##[3:17] s_second_half)
        else $error("word peripheral access not split low first");
    AST_TRUNCATE: assert property (
        o_go && !o_split |=> dn_addr == $past(o_addr[27:0]))
        else $error("operand address not truncated");
    AST_ALIAS_RAM: assert property (
        o_go && o_phys[27:26] == ALIAS_TAG && ram_hit(o_phys)
        |=> dn_region == RGN_RAM && dn_req)
        else $error("RAM alias not decoded");
    AST_WIN_READ: assert property (
        reg_rd && reg_addr == WIN_CTRL_ADDR |=>
        reg_rdata == (win_en_q ? WIN_RD_ON : WIN_RD_OFF) &&
        !reg_rdata[WIN_ZERO_BIT])
        else $error("window control read value wrong");
    AST_WAIT_LAYOUT: assert property (
        wr_wait |=> wait_q == ($past(reg_wdata[7:0]) & WAIT_MASK))
        else $error("wait register write wrong");
    AST_UNMAPPED_ZERO: assert property (
        o_go && o_rgn == RGN_NONE |=> !dn_req ##3 op_done &&
        op_rdata == 32'h00000000)
        else $error("unassigned access did not complete with zero");
endmodule

// ===== tb/far_side_model.sv
// memory and peripheral model on the far side of the bridge
`timescale 1ns/100ps

module far_side_model (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // access from the bridge
    input wire logic dn_req,
    input wire bridge_map_pkg::region_t dn_region,
    input wire logic [27:0] dn_addr,
    input wire logic [2:0] setup_wait,
    input wire logic [2:0] strobe_wait,
    // read data back
    output logic [31:0] dn_rdata
);
    import bridge_map_pkg::*;

    logic [4:0] left_q;
    logic [15:0] addr_q;
    logic [15:0] a;

    // remaining access cycles after the request cycle
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            left_q <= 5'h00;
            addr_q <= 16'h0000;
        end else if (dn_req) begin
            addr_q <= dn_addr[15:0];
            case (dn_region)
                RGN_ROM: left_q <= 5'h02;
                RGN_RAM: left_q <= 5'h00;
                default: left_q <= 5'h02 + {2'h0, setup_wait}
                    + {2'h0, strobe_wait};
            endcase
        end else if (left_q != 5'h00) begin
            left_q <= left_q - 5'h01;
        end
    end

    // data valid only during the access, inverted once it ends
    assign a = dn_req ? dn_addr[15:0] : addr_q;
    assign dn_rdata = (dn_req || left_q != 5'h00) ? {~a, a} : {a, ~a};
endmodule

// ===== tb/testbench.sv
// self-checking testbench for the core bus bridge
`timescale 1ns/100ps

module testbench;
    import bridge_map_pkg::*;

    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic fetch_req = 1'b0, fetch_branch = 1'b0, exc_ack = 1'b0;
    logic [31:0] fetch_disp = 32'h0, op_base = 32'h0, op_disp = 32'h0;
    logic [7:0] exc_code = 8'h00;
    logic op_req = 1'b0, op_we = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    size_t op_size = SZ_BYTE;
    logic [31:0] op_wdata = 32'h0, reg_addr = 32'h0, dn_rdata;
    logic [15:0] reg_wdata = 16'h0, reg_rdata;
    logic fetch_done, fetch_fault, op_busy, op_done, dn_req, dn_we;
    logic window_access_enable;
    logic [31:0] program_counter, op_rdata, dn_wdata, lf, t, nxt;
    region_t dn_region;
    size_t dn_size;
    logic [27:0] dn_addr;
    logic [13:0] window_base_field;
    logic [2:0] setup_wait, strobe_wait;
    int errors = 0;
    int num_checks = 0;

    always #4 sys_clk = ~sys_clk;

    core_bus_bridge i_dut (.sys_clk(sys_clk), .reset_n(reset_n),
        .fetch_req(fetch_req), .fetch_branch(fetch_branch),
        .fetch_disp(fetch_disp), .exc_ack(exc_ack), .exc_code(exc_code),
        .fetch_done(fetch_done), .fetch_fault(fetch_fault),
        .program_counter(program_counter), .op_req(op_req),
        .op_base(op_base), .op_disp(op_disp), .op_size(op_size),
        .op_we(op_we), .op_wdata(op_wdata), .op_busy(op_busy),
        .op_done(op_done), .op_rdata(op_rdata), .dn_req(dn_req),
        .dn_region(dn_region), .dn_addr(dn_addr), .dn_we(dn_we),
        .dn_size(dn_size), .dn_wdata(dn_wdata), .dn_rdata(dn_rdata),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .window_access_enable(window_access_enable),
        .window_base_field(window_base_field),
        .setup_wait(setup_wait), .strobe_wait(strobe_wait));

    far_side_model i_far (.sys_clk(sys_clk), .reset_n(reset_n),
        .dn_req(dn_req), .dn_region(dn_region), .dn_addr(dn_addr),
        .setup_wait(setup_wait), .strobe_wait(strobe_wait),
        .dn_rdata(dn_rdata));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr(logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    function automatic logic [31:0] pat(logic [27:0] ad);
        return {~ad[15:0], ad[15:0]};
    endfunction

    task automatic close_out;
        if (errors == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask

    task automatic reg_write(logic [31:0] ad, logic [15:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= ad;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(logic [31:0] ad, logic [15:0] exp);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= ad;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk("reg read", {16'h0, reg_rdata}, {16'h0, exp});
    endtask

    task automatic fetch(logic br, logic ex, logic [31:0] disp,
            logic [31:0] epc, int lat, logic flt);
        int n;
        @(posedge sys_clk);
        fetch_req <= ~ex;
        exc_ack <= ex;
        exc_code <= disp[7:0];
        fetch_branch <= br;
        fetch_disp <= disp;
        @(posedge sys_clk);
        fetch_req <= 1'b0;
        exc_ack <= 1'b0;
        n = 0;
        #1;
        while (fetch_done !== 1'b1 && n < 40) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        chk("fetch latency", n, lat);
        chk("fetch fault", {31'h0, fetch_fault}, {31'h0, flt});
        if (!flt) chk("pc", program_counter, epc);
    endtask

    task automatic op(logic [31:0] b, logic [31:0] d, size_t sz,
            logic we, logic [31:0] wd, region_t er, int lat,
            logic [27:0] ea, logic [31:0] erd);
        int n;
        int k;
        region_t rg;
        logic [27:0] ad;
        logic [15:0] w[2];
        logic [2:0] kd;
        size_t es;
        @(posedge sys_clk);
        op_req <= 1'b1;
        op_base <= b;
        op_disp <= d;
        op_size <= sz;
        op_we <= we;
        op_wdata <= wd;
        @(posedge sys_clk);
        op_req <= 1'b0;
        n = 0;
        k = 0;
        rg = RGN_NONE;
        ad = 28'h0;
        w[0] = 16'h0;
        w[1] = 16'h0;
        forever begin
            #1;
            if (n == 0) chk("busy", {31'h0, op_busy}, 32'h1);
            if (dn_req === 1'b1) begin
                if (k == 0) rg = dn_region;
                if (k == 0) ad = dn_addr;
                if (k == 0) kd = {dn_we, dn_size};
                if (k < 2) w[k] = dn_wdata[15:0];
                k++;
            end
            if (op_done === 1'b1 || n > 60) break;
            @(posedge sys_clk);
            n++;
        end
        chk("op latency", n, lat);
        es = (er == RGN_PERI || er == RGN_WIN) && sz == SZ_WORD ? SZ_HALF : sz;
        if (er != RGN_NONE) chk("kind", 32'(kd), {29'h0, we, es});
        chk("op region", 32'(rg), 32'(er));
        if (ea != 28'h0) chk("dn addr", {4'h0, ad}, {4'h0, ea});
        if (!we && ea != 28'h0 || er == RGN_NONE) begin
            if (sz == SZ_HALF) begin
                chk("op half", {16'h0, op_rdata[15:0]}, erd);
            end else begin
                chk("op data", op_rdata, erd);
            end
        end
        if (we && sz == SZ_WORD) chk("halves", {w[1], w[0]}, wd);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        lf = 32'h87D64CF4;
        repeat (5) @(posedge sys_clk);
        reset_n <= 1'b1;
        #1;
        chk("pc reset", program_counter, 32'h0);
        chk("waits", {26'h0, setup_wait, strobe_wait}, 32'h3F);
        reg_read(32'hFFFFF06E, 16'h0077);
        reg_read(32'hFFFFF064, 16'h0000);
        op(32'hFFFFF100, 32'h0, SZ_HALF, 1'b0, 32'h0, RGN_PERI, 17,
            28'hFFFF100, 32'h0000F100);
        reg_write(32'hFFFFF06E, 16'h00FF);
        reg_read(32'hFFFFF06E, 16'h0077);
        for (int i = 0; i < 4; i++) begin
            lf = lfsr(lf);
            reg_write(32'hFFFFF06E, {8'h00, lf[7:0]});
            reg_read(32'hFFFFF06E, {8'h00, lf[7:0] & 8'h77});
            chk("setup", {29'h0, setup_wait}, {29'h0, lf[6:4]});
            chk("strobe", {29'h0, strobe_wait}, {29'h0, lf[2:0]});
        end
        reg_write(32'hFFFFF06E, 16'h0012);
        reg_write(32'hFFFFF070, 16'hFFFF);
        reg_read(32'hFFFFF070, 16'h0000);
        reg_write(32'hFFFFF064, 16'hC040);
        reg_read(32'hFFFFF064, 16'h8FFB);
        chk("win en", {31'h0, window_access_enable}, 32'h1);
        chk("win base", {18'h0, window_base_field}, 32'h40);
        op(32'h00001230, 32'h4, SZ_WORD, 1'b0, 32'h0, RGN_ROM, 3,
            28'h0001234, pat(28'h0001234));
        op(32'hFFFFFFF0, 32'h20, SZ_WORD, 1'b0, 32'h0, RGN_ROM, 3,
            28'h0000010, pat(28'h0000010));
        op(32'hE0000100, 32'h0, SZ_WORD, 1'b0, 32'h0, RGN_ROM, 3,
            28'h0000100, pat(28'h0000100));
        op(32'hFFFFC100, 32'h0, SZ_WORD, 1'b0, 32'h0, RGN_RAM, 1,
            28'hFFFC100, pat(28'hFFFC100));
        op(32'hFFFFC200, 32'h1, SZ_BYTE, 1'b0, 32'h0, RGN_RAM, 1,
            28'hFFFC201, pat(28'hFFFC201));
        op(32'h03FFC100, 32'h0, SZ_WORD, 1'b0, 32'h0, RGN_RAM, 1,
            28'h0, 32'h0);
        op(32'h03FFBFFC, 32'h0, SZ_WORD, 1'b0, 32'h0, RGN_NONE, 3,
            28'h0, 32'h0);
        op(32'hFFFFF000, 32'h0, SZ_HALF, 1'b0, 32'h0, RGN_PERI, 6,
            28'hFFFF000, 32'h0000F000);
        op(32'hFFFFF102, 32'h0, SZ_WORD, 1'b0, 32'h0, RGN_PERI, 12,
            28'hFFFF100, 32'hF102F100);
        op(32'hFFFFF200, 32'h0, SZ_WORD, 1'b1, 32'hBEEF1234, RGN_PERI, 12,
            28'hFFFF200, 32'h0);
        op(32'h00102000, 32'h0, SZ_HALF, 1'b0, 32'h0, RGN_WIN, 6,
            28'h0102000, 32'h00002000);
        op(32'h05000000, 32'h0, SZ_WORD, 1'b0, 32'h0, RGN_NONE, 3,
            28'h0, 32'h0);
        reg_write(32'hFFFFF064, 16'h0000);
        reg_read(32'hFFFFF064, 16'h0000);
        op(32'h00102000, 32'h0, SZ_WORD, 1'b0, 32'h0, RGN_NONE, 3,
            28'h0, 32'h0);
        for (int i = 0; i < 4; i++) begin
            lf = lfsr(lf);
            t = lf & 32'h000FFFFC;
            op(t, 32'h0, SZ_WORD, 1'b0, 32'h0, RGN_ROM, 3, t[27:0],
                pat(t[27:0]));
        end
        fetch(1'b0, 1'b0, 32'h0, 32'h0, 1, 1'b0);
        fetch(1'b0, 1'b0, 32'h0, 32'h4, 1, 1'b0);
        fetch(1'b1, 1'b0, 32'hFFFFFFFC, 32'h4, 2, 1'b0);
        fetch(1'b1, 1'b0, 32'h03FFEFF8, 32'h0, 1, 1'b1);
        fetch(1'b0, 1'b0, 32'h0, 32'h8, 1, 1'b0);
        fetch(1'b0, 1'b1, 32'h5, 32'h50, 2, 1'b0);
        nxt = 32'h54;
        for (int i = 0; i < 3; i++) begin
            lf = lfsr(lf);
            t = lf & 32'h000FFFFC;
            fetch(1'b1, 1'b0, (t - nxt) & 32'h03FFFFFF, t, 2, 1'b0);
            nxt = t + 32'h4;
        end
        close_out();
    end

    // ------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        close_out();
    end
endmodule
